// ==== ppi_mem_model.sv ====
`default_nettype none
// memory side of the context exchange, answering each cycle with a one-cycle ack
module ppi_mem_model (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // exchange port
   input  wire ppi_pkg::ppi_mem_t ctxMem,
   input  wire logic              slow,
   output logic                   ctxAck,
   output logic [15:0]            ctxRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];
   logic [15:0] rdQ;
   logic [1:0]  waitQ;

   // ack after none or three idle cycles; never two acks in a row
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctxAck <= 1'b0;
         waitQ  <= 2'h0;
      end else begin
         ctxAck <= 1'b0;
         if (ctxMem.req && !ctxAck) begin
            if (slow && waitQ != 2'h3) begin
               waitQ <= waitQ + 2'h1;
            end else begin
               waitQ  <= 2'h0;
               ctxAck <= 1'b1;
               if (ctxMem.wr) begin
                  mem[ctxMem.addr[7:0]] <= ctxMem.data;
               end
               rdQ <= mem[ctxMem.addr[7:0]];
            end
         end
      end
   end

   // data only valid with ack; inverse otherwise so stale reads show up
   assign ctxRdData = ctxAck ? rdQ : ~rdQ;
endmodule
`default_nettype wire

// ==== ppi_pkg.sv ====
`default_nettype none
package ppi_pkg;
   // level count: sixteen in basic form, grows in groups of four to 64
   localparam int unsigned LEVEL_GROUP  = 4;
   localparam int unsigned LEVELS       = 16;
   localparam int unsigned LEVEL_MAX    = 64;
   localparam int unsigned LEVEL_W      = 6;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned MODULE_CNT   = 16;
   localparam int unsigned MODULE_SHIFT = 12;            // 4,096-word modules
   localparam int unsigned BYTE_W       = 8;
   // context block: acc, index, status, location per level
   localparam int unsigned CTX_WORDS    = 4;
   localparam int unsigned CTX_SHIFT    = 2;
   localparam logic [15:0] CTX_BASE     = 16'h0040;
   localparam logic [1:0]  SLOT_ACC     = 2'h0;
   localparam logic [1:0]  SLOT_IDX     = 2'h1;
   localparam logic [1:0]  SLOT_STAT    = 2'h2;
   localparam logic [1:0]  SLOT_LOC     = 2'h3;
   // exchange must finish in six microseconds
   localparam int unsigned SWAP_NS      = 6000;
   localparam int unsigned CLK_NS       = 40;
   localparam int unsigned SWAP_CYC     = SWAP_NS / CLK_NS;
   localparam logic [7:0]  SWAP_CYC_8   = 8'(SWAP_CYC);
   localparam logic [2:0]  LAST_WORD    = 3'h7;          // 4 saves + 4 loads
   localparam logic [LEVEL_W-1:0] IDLE_LEVEL = 6'h3f;

   typedef enum logic [2:0] {
      PPI_RUN  = 3'b000,
      PPI_WAIT = 3'b001,
      PPI_SWAP = 3'b011,
      PPI_DONE = 3'b010
   } ppi_state_t;

   // one memory cycle offered to the memory
   typedef struct packed {
      logic              req;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ppi_mem_t;

   // processor context exchanged per level
   typedef struct packed {
      logic [DATA_W-1:0] acc;
      logic [DATA_W-1:0] idx;
      logic [DATA_W-1:0] stat;
      logic [DATA_W-1:0] loc;
   } ppi_ctx_t;
endpackage
`default_nettype wire

// ==== ppi_sync_bank.sv ====
`default_nettype none
// two-flop synchroniser for a bank of asynchronous request pins
module ppi_sync_bank #(
   parameter int unsigned W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async,
   output logic      [W-1:0] synced
);
   logic [W-1:0] meta_q;

   // first stage read only by second stage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         synced <= '0;
      end else begin
         meta_q <= async;
         synced <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== ppi_unit.sv ====
`default_nettype none
module ppi_unit (
   // clock and reset
   input  wire logic                         mclk,
   input  wire logic                         rst_n,
   // request sources
   input  wire logic [ppi_pkg::LEVELS-1:0]   extReq,
   input  wire logic                         progSet,
   input  wire logic [ppi_pkg::LEVEL_W-1:0]  progLevel,
   input  wire logic                         levelDone,
   // processor handshake
   input  wire logic                         instrEnd,
   input  wire ppi_pkg::ppi_ctx_t            cpuCtx,
   // memory traffic checked for faults
   input  wire logic                         memWr,
   input  wire logic [ppi_pkg::ADDR_W-1:0]   memAddr,
   input  wire logic                         memRdValid,
   input  wire logic [ppi_pkg::DATA_W-1:0]   memRdData,
   input  wire logic [1:0]                   memRdPar,
   input  wire logic [ppi_pkg::MODULE_CNT-1:0] protectSw,
   // exchange memory port
   output ppi_pkg::ppi_mem_t                 ctxMem_q,
   input  wire logic                         ctxAck,
   input  wire logic [ppi_pkg::DATA_W-1:0]   ctxRdData,
   // to processor
   output ppi_pkg::ppi_ctx_t                 newCtx_q,
   output logic                              cpuHold_q,
   output logic                              ctxLoad_q,
   output logic [ppi_pkg::LEVEL_W-1:0]       activeLevel_q,
   output logic                              parityErr_q,
   output logic                              protectErr_q
);
   localparam int unsigned N = ppi_pkg::LEVELS;
   localparam logic [5:0] PAR_LVL  = 6'(N - 1);   // fault levels sit lowest
   localparam logic [5:0] PROT_LVL = 6'(N - 2);

   ppi_pkg::ppi_state_t stateQ, stateD;
   logic [N-1:0] pendQ, extSync, setMask, clrMask;
   logic [N-1:0] aboveMask;
   logic [2:0]   wordQ;
   logic [7:0]   swapCntQ;
   logic [5:0]   winner, prevLevelQ, tgtLevelQ;
   logic [ppi_pkg::MODULE_CNT-1:0] protSync;
   logic         anyPend, preempt;
   ppi_pkg::ppi_ctx_t saveCtxQ;

   // groups of four only, never past the ceiling
   initial begin
      if (N % ppi_pkg::LEVEL_GROUP != 0 || N > ppi_pkg::LEVEL_MAX)
         $error("level count must be a group of four, at most 64");
   end

   ppi_sync_bank #(.W(N)) uSync (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .async  (extReq),
      .synced (extSync)
   );

   // manual protect switches are asynchronous as well
   ppi_sync_bank #(.W(ppi_pkg::MODULE_CNT)) uProtSync (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .async  (protectSw),
      .synced (protSync)
   );

   // fault detection: parity even per byte, protected module write
   wire parLo   = ^memRdData[ppi_pkg::BYTE_W-1:0] ^ memRdPar[0];
   wire parHi   = ^memRdData[ppi_pkg::DATA_W-1:ppi_pkg::BYTE_W] ^ memRdPar[1];
   wire parBad  = memRdValid && (parLo || parHi);
   wire [3:0] modSel = memAddr[ppi_pkg::ADDR_W-1:ppi_pkg::MODULE_SHIFT];
   wire protBad = memWr && protSync[modSel];

   // set sources: pins, program, faults; set beats clear
   always_comb begin
      setMask = extSync;
      if (progSet && progLevel < 6'(N)) setMask[progLevel[3:0]] = 1'b1;
      if (parBad)  setMask[PAR_LVL[3:0]]  = 1'b1;
      if (protBad) setMask[PROT_LVL[3:0]] = 1'b1;
      clrMask = '0;
      if (stateQ == ppi_pkg::PPI_DONE) clrMask[activeLevel_q[3:0]] = 1'b1;
   end

   // priority encode: index 0 highest
   always_comb begin
      winner  = ppi_pkg::IDLE_LEVEL;
      anyPend = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pendQ[i]) begin
            winner  = 6'(i);
            anyPend = 1'b1;
         end
      end
   end
   always_comb begin
      aboveMask = '0;
      for (int i = 0; i < N; i++) aboveMask[i] = (6'(i) < tgtLevelQ);
   end
   assign preempt = anyPend && (winner < activeLevel_q);

   // context address: base + level*4 + slot
   wire [1:0] slot = wordQ[1:0];
   // loads use the target fixed at entry, so a late request cannot mix two levels
   wire [5:0] ctxLvl = wordQ[2] ? tgtLevelQ : activeLevel_q;
   wire [15:0] ctxAddr = ppi_pkg::CTX_BASE + {8'h00, ctxLvl, slot};
   wire [15:0] saveWord = (slot == ppi_pkg::SLOT_ACC)  ? saveCtxQ.acc  :
                          (slot == ppi_pkg::SLOT_IDX)  ? saveCtxQ.idx  :
                          (slot == ppi_pkg::SLOT_STAT) ? saveCtxQ.stat : saveCtxQ.loc;
   wire skipSave = (activeLevel_q == ppi_pkg::IDLE_LEVEL);
   wire lastWord = (wordQ == ppi_pkg::LAST_WORD) && ctxAck;

   // exchange sequencer
   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         ppi_pkg::PPI_RUN:  if (preempt) stateD = ppi_pkg::PPI_WAIT;
         ppi_pkg::PPI_WAIT: if (instrEnd) stateD = ppi_pkg::PPI_SWAP;
         ppi_pkg::PPI_SWAP: if (lastWord) stateD = ppi_pkg::PPI_RUN;
         ppi_pkg::PPI_DONE: stateD = ppi_pkg::PPI_RUN;
      endcase
      if (stateQ == ppi_pkg::PPI_RUN && levelDone) stateD = ppi_pkg::PPI_DONE;
   end

   // pending latch holds until serviced
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pendQ <= '0;
      else        pendQ <= (pendQ & ~clrMask) | setMask;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stateQ        <= ppi_pkg::PPI_RUN;
         activeLevel_q <= ppi_pkg::IDLE_LEVEL;
         prevLevelQ    <= ppi_pkg::IDLE_LEVEL;
         tgtLevelQ     <= ppi_pkg::IDLE_LEVEL;
         wordQ         <= '0;
         swapCntQ      <= '0;
         saveCtxQ      <= '0;
         newCtx_q      <= '0;
         ctxLoad_q     <= 1'b0;
         cpuHold_q     <= 1'b0;
         ctxMem_q      <= '0;
         parityErr_q   <= 1'b0;
         protectErr_q  <= 1'b0;
      end else begin
         stateQ       <= stateD;
         ctxLoad_q    <= 1'b0;
         parityErr_q  <= parBad;
         protectErr_q <= protBad;
         cpuHold_q    <= (stateD == ppi_pkg::PPI_SWAP);
         if (stateQ == ppi_pkg::PPI_WAIT && instrEnd) begin
            saveCtxQ  <= cpuCtx;
            tgtLevelQ <= winner;
            wordQ     <= skipSave ? 3'h4 : 3'h0;
            swapCntQ <= '0;
         end
         if (stateQ == ppi_pkg::PPI_SWAP) begin
            swapCntQ <= swapCntQ + 8'h01;
            ctxMem_q.req  <= !ctxAck;
            ctxMem_q.wr   <= !wordQ[2];
            ctxMem_q.addr <= ctxAddr;
            ctxMem_q.data <= saveWord;
            if (ctxAck && ctxMem_q.req) begin
               if (wordQ[2]) begin
                  unique case (slot)
                     ppi_pkg::SLOT_ACC:  newCtx_q.acc  <= ctxRdData;
                     ppi_pkg::SLOT_IDX:  newCtx_q.idx  <= ctxRdData;
                     ppi_pkg::SLOT_STAT: newCtx_q.stat <= ctxRdData;
                     ppi_pkg::SLOT_LOC:  newCtx_q.loc  <= ctxRdData;
                  endcase
               end
               if (wordQ == ppi_pkg::LAST_WORD) begin
                  ctxLoad_q     <= 1'b1;
                  prevLevelQ    <= activeLevel_q;
                  activeLevel_q <= tgtLevelQ;
                  ctxMem_q.req  <= 1'b0;
               end else begin
                  wordQ <= wordQ + 3'h1;
               end
            end
         end
         // finished level returns to the one the last exchange displaced
         if (stateQ == ppi_pkg::PPI_DONE) activeLevel_q <= prevLevelQ;
      end
   end

   // exchange stays inside its budget
   property p_swapBudget;
      @(posedge mclk) disable iff (!rst_n)
      stateQ == ppi_pkg::PPI_SWAP |-> swapCntQ < ppi_pkg::SWAP_CYC_8;
   endproperty
   a_swapBudget: assert property (p_swapBudget) else $error("exchange over budget");

   property p_waitEnd;
      @(posedge mclk) disable iff (!rst_n)
      stateQ == ppi_pkg::PPI_WAIT && instrEnd |=> stateQ == ppi_pkg::PPI_SWAP && cpuHold_q;
   endproperty
   a_waitEnd: assert property (p_waitEnd) else $error("no response at instruction end");

   property p_holdPend;
      @(posedge mclk) disable iff (!rst_n)
      pendQ != '0 && stateQ != ppi_pkg::PPI_DONE |=> (pendQ & $past(pendQ)) == $past(pendQ);
   endproperty
   a_holdPend: assert property (p_holdPend) else $error("pending request lost");

   property p_parity;
      @(posedge mclk) disable iff (!rst_n)
      parBad |=> parityErr_q ##0 pendQ[PAR_LVL[3:0]];
   endproperty
   a_parity: assert property (p_parity) else $error("parity fault not raised");

   property p_protect;
      @(posedge mclk) disable iff (!rst_n)
      protBad |=> protectErr_q && pendQ[PROT_LVL[3:0]];
   endproperty
   a_protect: assert property (p_protect) else $error("protect fault not raised");

   property p_extReq;
      @(posedge mclk) disable iff (!rst_n)
      extSync[0] |=> pendQ[0];
   endproperty
   a_extReq: assert property (p_extReq) else $error("pin request not latched");

   property p_priority;
      @(posedge mclk) disable iff (!rst_n)
      stateQ == ppi_pkg::PPI_WAIT && instrEnd |=> ($past(pendQ) & aboveMask) == '0;
   endproperty
   a_priority: assert property (p_priority) else $error("lower level granted");

   property p_ctxAddr;
      @(posedge mclk) disable iff (!rst_n)
      ctxMem_q.req |-> ctxMem_q.addr >= ppi_pkg::CTX_BASE
         && ctxMem_q.addr < ppi_pkg::CTX_BASE + 16'(N * ppi_pkg::CTX_WORDS);
   endproperty
   a_ctxAddr: assert property (p_ctxAddr) else $error("context address outside block");

   property p_levels;
      @(posedge mclk) disable iff (!rst_n)
      activeLevel_q < 6'(N) || activeLevel_q == ppi_pkg::IDLE_LEVEL;
   endproperty
   a_levels: assert property (p_levels) else $error("active level out of range");

   c_swap:    cover property (@(posedge mclk) disable iff (!rst_n) ctxLoad_q);
   c_nest:    cover property (@(posedge mclk) disable iff (!rst_n)
                 ctxLoad_q && prevLevelQ != ppi_pkg::IDLE_LEVEL);
   c_done:    cover property (@(posedge mclk) disable iff (!rst_n) stateQ == ppi_pkg::PPI_DONE);
   c_parity:  cover property (@(posedge mclk) disable iff (!rst_n) parityErr_q);
endmodule
`default_nettype wire

// ==== ppi_unit_tb.sv ====
`default_nettype none
module ppi_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk, rst_n, progSet, levelDone, instrEnd, memWr, memRdValid, slow;
   logic              ctxAck, cpuHold_q, ctxLoad_q, parityErr_q, protectErr_q;
   logic [15:0]       extReq, memAddr, memRdData, protectSw, ctxRdData;
   logic [5:0]        progLevel, activeLevel_q;
   logic [1:0]        memRdPar;
   ppi_pkg::ppi_ctx_t cpuCtx, newCtx_q;
   ppi_pkg::ppi_mem_t ctxMem_q;
   int                mismatches, checks;

   ppi_unit dut (.mclk, .rst_n, .extReq, .progSet, .progLevel, .levelDone, .instrEnd, .cpuCtx,
      .memWr, .memAddr, .memRdValid, .memRdData, .memRdPar, .protectSw, .ctxMem_q, .ctxAck,
      .ctxRdData, .newCtx_q, .cpuHold_q, .ctxLoad_q, .activeLevel_q, .parityErr_q, .protectErr_q);
   ppi_mem_model mdl (.mclk, .rst_n, .ctxMem(ctxMem_q), .slow, .ctxAck, .ctxRdData);

   // free-running processor clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // keep instructions ending until the wanted level is loaded; bounded
   task automatic serve(input logic [5:0] lvl, input bit first);
      int cyc;
      int held;
      int most;
      bit done;
      cyc = 0; held = 0; most = 0; done = 0;
      while (!done && cyc < 800) begin
         @(posedge mclk);
         instrEnd <= (cyc % 5 == 4);
         #1;
         cyc++;
         held = (cpuHold_q === 1'b1) ? held + 1 : 0;
         most = (held > most) ? held : most;
         done = (ctxLoad_q === 1'b1) && (first || activeLevel_q === lvl);
      end
      @(posedge mclk);
      instrEnd <= 1'b0;
      if (!done) begin
         $display("BAD %0t no exchange finished", $time);
         mismatches++;
         wrap_up();
      end
      chk(64'(activeLevel_q), 64'(lvl));
      chk(64'(most > 0 && most <= 150), 64'h1);
   endtask

   // entry from idle on a pin request
   task automatic t_entry;
      for (int i = 0; i < 4; i++) mdl.mem[8'h48 + i] = 16'h2000 + 16'(i);
      @(posedge mclk);
      extReq[2] <= 1'b1;
      repeat (6) @(posedge mclk);
      instrEnd <= 1'b1;
      @(posedge mclk);
      instrEnd <= 1'b0;
      #1;
      chk(64'(cpuHold_q), 64'h1);
      serve(6'h02, 1'b1);
      chk(newCtx_q, 64'h2000_2001_2002_2003);
   endtask

   // lower program request waits, then runs once level 2 is done
   task automatic t_low;
      @(posedge mclk);
      progSet   <= 1'b1;
      progLevel <= 6'h14;
      @(posedge mclk);
      progLevel <= 6'h09;
      @(posedge mclk);
      progSet <= 1'b0;
      repeat (20) begin
         @(posedge mclk);
         instrEnd <= !instrEnd;
      end
      #1;
      chk(64'(activeLevel_q), 64'h2);
      chk(64'(cpuHold_q), 64'h0);
      @(posedge mclk);
      extReq   <= 16'h0000;
      instrEnd <= 1'b0;
      repeat (4) @(posedge mclk);
      levelDone <= 1'b1;
      @(posedge mclk);
      levelDone <= 1'b0;
      serve(6'h09, 1'b0);
   endtask

   // two pins at once against a slow memory; level 9 context saved
   task automatic t_pre;
      for (int i = 0; i < 4; i++) mdl.mem[8'h40 + i] = 16'h0a00 + 16'(i);
      @(posedge mclk);
      slow   <= 1'b1;
      extReq <= 16'h0021;
      serve(6'h00, 1'b1);
      chk(newCtx_q, 64'h0a00_0a01_0a02_0a03);
      for (int i = 0; i < 4; i++) chk(64'(mdl.mem[8'h64 + i]), 64'h9000 + 64'(i));
      slow <= 1'b0;
   endtask

   // one memory access; the flag may land one or two edges later
   task automatic t_fault(input logic v, input logic w, input logic [1:0] par, input logic [15:0] a,
                          input logic eP, input logic eR);
      logic p;
      logic r;
      @(posedge mclk);
      memRdValid <= v;
      memWr      <= w;
      memRdPar   <= par;
      memAddr    <= a;
      @(posedge mclk);
      memRdValid <= 1'b0;
      memWr      <= 1'b0;
      #1;
      p = parityErr_q;
      r = protectErr_q;
      @(posedge mclk);
      #1;
      p |= parityErr_q;
      r |= protectErr_q;
      chk(64'(p), 64'(eP));
      chk(64'(r), 64'(eR));
   endtask

   // main sequence
   initial begin
      mismatches = 0; checks = 0; rst_n = 1'b0; extReq = 16'h0000; progSet = 1'b0;
      progLevel = 6'h00; levelDone = 1'b0; instrEnd = 1'b0; cpuCtx = 64'h9000_9001_9002_9003;
      memWr = 1'b0; memAddr = 16'h0000; memRdValid = 1'b0; memRdData = 16'ha5c3;
      memRdPar = 2'h0; protectSw = 16'h0008; slow = 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk(64'(activeLevel_q), 64'h3f);
      chk(64'({cpuHold_q, ctxLoad_q, parityErr_q, protectErr_q}), 64'h0);
      chk(64'(ctxMem_q), 64'h0);
      chk(64'(ppi_pkg::LEVELS % 4 == 0 && ppi_pkg::LEVELS <= 64), 64'h1);
      t_entry();
      t_low();
      t_pre();
      t_fault(1'b1, 1'b0, 2'h0, 16'h0000, 1'b0, 1'b0);
      t_fault(1'b1, 1'b0, 2'h1, 16'h0000, 1'b1, 1'b0);
      t_fault(1'b1, 1'b0, 2'h2, 16'h0000, 1'b1, 1'b0);
      t_fault(1'b0, 1'b1, 2'h0, 16'h3abc, 1'b0, 1'b1);
      t_fault(1'b0, 1'b1, 2'h0, 16'h4abc, 1'b0, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
